/* File: hw/pphi_pkg.sv */
// Purpose: Shared constants for the dual parallel port with handshake lines
// Assumes: One 40 MHz clock, processor bus presented as plain ports
// Notes: Bit positions of the two control registers and register selects
`default_nettype none
package pphi_pkg;
   localparam int PORT_W = 8;
   // Control register field positions
   localparam int CTL_STB_IRQEN = 0;
   localparam int CTL_STB_EDGE = 1;
   localparam int CTL_ACCESS = 2;
   localparam int CTL_LINE_B3 = 3;
   localparam int CTL_LINE_B4 = 4;
   localparam int CTL_LINE_OUT = 5;
   localparam int CTL_FLAG_CTL = 6;
   localparam int CTL_FLAG_STB = 7;
   localparam int CTL_WR_W = 6;
   // Register select codes
   localparam logic [1:0] SEL_PORT_A = 2'h0;
   localparam logic [1:0] SEL_CTL_A = 2'h1;
   localparam logic [1:0] SEL_PORT_B = 2'h2;
   localparam logic [1:0] SEL_CTL_B = 2'h3;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // Control line modes
   typedef enum logic [1:0] {LM_INPUT, LM_HANDSHAKE, LM_PULSE, LM_STATIC} pphi_line_e;
endpackage : pphi_pkg
`default_nettype wire

/* File: hw/pphi_edge_sync.sv */
// Purpose: Three-stage synchroniser with selectable active edge detection
// Assumes: Input comes from a pin outside the clock domain
// Notes: A change counts once the second and third stages agree
`default_nettype none
module pphi_edge_sync
(
   input wire logic clk, // System clock
   input wire logic rstn, // Async reset, active low
   input wire logic pinIn, // Raw pin level
   input wire logic riseSel, // 1 selects rising edge
   output logic level, // Filtered level
   output logic activeEdge // One-cycle pulse on selected edge
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic level_ff;

   // Stage one feeds stage two only, to keep metastability contained
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
      end
      else
      begin
         s1_ff <= pinIn;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // Accept a new level when stages two and three agree
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         level_ff <= 1'b0; // Matches cleared stages, no false edge
      else if (s2_ff == s3_ff)
         level_ff <= s3_ff;
   end

   assign level = level_ff;
   assign activeEdge = (s2_ff == s3_ff) && (s3_ff != level_ff) && (s3_ff == riseSel);
endmodule : pphi_edge_sync
`default_nettype wire

/* File: hw/pphi_ctl_side.sv */
// Purpose: Flags, interrupt request and control line logic for one port side
// Assumes: Strobes from the bus decoder are single-cycle pulses
// Notes: Flag set wins over a same-cycle clear by a port read
`default_nettype none
module pphi_ctl_side
(
   input wire logic clk, // System clock
   input wire logic rstn, // Async reset, active low
   input wire logic [7:0] ctlReg, // Control register, bits 7..0, flags in 7 and 6
   input wire logic strobeEdge, // Selected edge of strobe input
   input wire logic ctlEdge, // Selected edge of control line
   input wire logic flagClr, // Port data read
   input wire logic pulseTrig, // Access that fires a pulse
   input wire logic hsTrig, // Access that starts handshake
   output logic flagStb, // Strobe flag
   output logic flagCtl, // Control line flag
   output logic irqOe, // Interrupt pull-down enable
   output logic lineOut, // Control line output level
   output logic lineOe // Control line output enable
);
   import pphi_pkg::*;
   logic flagStb_ff;
   logic flagCtl_ff;
   logic lineLvl_ff;
   pphi_line_e mode;

   // Mode decode from bits 5,4,3
   always_comb
   begin
      if (!ctlReg[CTL_LINE_OUT])
         mode = LM_INPUT;
      else if (ctlReg[CTL_LINE_B4])
         mode = LM_STATIC;
      else if (ctlReg[CTL_LINE_B3])
         mode = LM_PULSE;
      else
         mode = LM_HANDSHAKE;
   end

   // Strobe flag is set regardless of its enable
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         flagStb_ff <= 1'b0;
      else if (strobeEdge)
         flagStb_ff <= 1'b1;
      else if (flagClr)
         flagStb_ff <= 1'b0;
   end

   // Control line flag only in input mode
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         flagCtl_ff <= 1'b0;
      else if (ctlEdge && mode == LM_INPUT)
         flagCtl_ff <= 1'b1;
      else if (flagClr)
         flagCtl_ff <= 1'b0;
   end

   // Output level per mode; pulse lasts one cycle
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         lineLvl_ff <= 1'b1;
      else
      begin
         case (mode)
            LM_STATIC: lineLvl_ff <= ctlReg[CTL_LINE_B3];
            LM_PULSE: lineLvl_ff <= !pulseTrig;
            LM_HANDSHAKE:
               if (hsTrig)
                  lineLvl_ff <= 1'b0;
               else if (strobeEdge)
                  lineLvl_ff <= 1'b1;
            default: lineLvl_ff <= 1'b1;
         endcase
      end
   end

   assign flagStb = flagStb_ff;
   assign flagCtl = flagCtl_ff;
   assign irqOe = (flagStb_ff && ctlReg[CTL_STB_IRQEN])
      || (flagCtl_ff && ctlReg[CTL_LINE_B3] && mode == LM_INPUT);
   assign lineOut = lineLvl_ff;
   assign lineOe = (mode != LM_INPUT);
endmodule : pphi_ctl_side
`default_nettype wire

/* File: hw/pphi_parallel_port.sv */
// Purpose: Dual 8-bit parallel port with strobe and control lines and irqs
// Assumes: Processor access arrives as one-cycle strobes on the system clock
// Notes: Register select, direction-access bit and port read-back as below
`default_nettype none
module pphi_parallel_port
(
   input wire logic clk, // System clock, 40 MHz
   input wire logic rstn, // Async reset, active low
   input wire logic busSel, // Chip selected for this access
   input wire logic busRd, // One-cycle read strobe
   input wire logic busWr, // One-cycle write strobe
   input wire logic [1:0] regSel, // Register select
   input wire logic [pphi_pkg::PORT_W-1:0] wrData, // Write data
   output logic [pphi_pkg::PORT_W-1:0] rdData, // Read data, registered
   input wire logic [pphi_pkg::PORT_W-1:0] portAIn, // Port A pin levels
   output logic [pphi_pkg::PORT_W-1:0] portAOut, // Port A drive levels
   output logic [pphi_pkg::PORT_W-1:0] portAOe, // Port A drive enables
   input wire logic [pphi_pkg::PORT_W-1:0] portBIn, // Port B pin levels
   output logic [pphi_pkg::PORT_W-1:0] portBOut, // Port B drive levels
   output logic [pphi_pkg::PORT_W-1:0] portBOe, // Port B drive enables
   input wire logic aStrobeIn, // Side A strobe pin
   input wire logic aCtlIn, // Side A control line in
   output logic aCtlOut, // Side A control line out
   output logic aCtlOe, // Side A control line enable
   input wire logic bStrobeIn, // Side B strobe pin
   input wire logic bCtlIn, // Side B control line in
   output logic bCtlOut, // Side B control line out
   output logic bCtlOe, // Side B control line enable
   output logic irqANOut, // Request A level, always low
   output logic irqANOe, // Request A pull-down enable
   output logic irqBNOut, // Request B level, always low
   output logic irqBNOe // Request B pull-down enable
);
   import pphi_pkg::*;

   logic [CTL_WR_W-1:0] controlA_ff;
   logic [CTL_WR_W-1:0] controlB_ff;
   logic [PORT_W-1:0] directionA_ff;
   logic [PORT_W-1:0] directionB_ff;
   logic [PORT_W-1:0] outputA_ff;
   logic [PORT_W-1:0] outputB_ff;
   logic [PORT_W-1:0] rdData_ff;
   logic [PORT_W-1:0] portASync1_ff;
   logic [PORT_W-1:0] portASync2_ff;
   logic [PORT_W-1:0] portASync3_ff;
   logic [PORT_W-1:0] portALvl_ff;
   logic [PORT_W-1:0] portBSync1_ff;
   logic [PORT_W-1:0] portBSync2_ff;
   logic [PORT_W-1:0] portBSync3_ff;
   logic [PORT_W-1:0] portBLvl_ff;
   logic [7:0] ctlAFull;
   logic [7:0] ctlBFull;
   logic rdPortA;
   logic rdPortB;
   logic wrPortB;
   logic anyAccess;
   logic aStbLvl;
   logic aStbEdge;
   logic aCtlLvl;
   logic aCtlEdge;
   logic bStbLvl;
   logic bStbEdge;
   logic bCtlLvl;
   logic bCtlEdge;
   logic flagAStb;
   logic flagACtl;
   logic flagBStb;
   logic flagBCtl;
   logic irqAOe;
   logic irqBOe;

   // Data location decode, used for both sides
   function automatic logic hitData(input logic [1:0] sel, input logic [1:0] code,
      input logic accessBit);
      hitData = (sel == code) && accessBit;
   endfunction : hitData

   function automatic logic hitDir(input logic [1:0] sel, input logic [1:0] code,
      input logic accessBit);
      hitDir = (sel == code) && !accessBit;
   endfunction : hitDir

   assign rdPortA = busSel && busRd && hitData(regSel, SEL_PORT_A, controlA_ff[CTL_ACCESS]);
   assign rdPortB = busSel && busRd && hitData(regSel, SEL_PORT_B, controlB_ff[CTL_ACCESS]);
   assign wrPortB = busSel && busWr && hitData(regSel, SEL_PORT_B, controlB_ff[CTL_ACCESS]);
   assign anyAccess = busSel && (busRd || busWr);

   // Control registers; flags live in the side modules
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         controlA_ff <= '0;
         controlB_ff <= '0;
      end
      else if (busSel && busWr)
      begin
         if (regSel == SEL_CTL_A)
            controlA_ff <= wrData[CTL_WR_W-1:0];
         if (regSel == SEL_CTL_B)
            controlB_ff <= wrData[CTL_WR_W-1:0];
      end
   end

   // Direction and output registers share an address, bit 2 picks
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         directionA_ff <= RESET_BYTE;
         directionB_ff <= RESET_BYTE;
         outputA_ff <= RESET_BYTE;
         outputB_ff <= RESET_BYTE;
      end
      else if (busSel && busWr)
      begin
         if (hitDir(regSel, SEL_PORT_A, controlA_ff[CTL_ACCESS]))
            directionA_ff <= wrData;
         if (hitData(regSel, SEL_PORT_A, controlA_ff[CTL_ACCESS]))
            outputA_ff <= wrData;
         if (hitDir(regSel, SEL_PORT_B, controlB_ff[CTL_ACCESS]))
            directionB_ff <= wrData;
         if (wrPortB)
            outputB_ff <= wrData;
      end
   end

   // Port pins pass three stages; second and third must agree
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         portASync1_ff <= RESET_BYTE;
         portASync2_ff <= RESET_BYTE;
         portASync3_ff <= RESET_BYTE;
         portBSync1_ff <= RESET_BYTE;
         portBSync2_ff <= RESET_BYTE;
         portBSync3_ff <= RESET_BYTE;
      end
      else
      begin
         portASync1_ff <= portAIn;
         portASync2_ff <= portASync1_ff;
         portASync3_ff <= portASync2_ff;
         portBSync1_ff <= portBIn;
         portBSync2_ff <= portBSync1_ff;
         portBSync3_ff <= portBSync2_ff;
      end
   end

   // Per-bit agreement filter
   genvar gi;
   generate
      for (gi = 0; gi < PORT_W; gi++)
      begin : g_filt
         always_ff @(posedge clk or negedge rstn)
         begin
            if (!rstn)
            begin
               portALvl_ff[gi] <= 1'b0;
               portBLvl_ff[gi] <= 1'b0;
            end
            else
            begin
               if (portASync2_ff[gi] == portASync3_ff[gi])
                  portALvl_ff[gi] <= portASync3_ff[gi];
               if (portBSync2_ff[gi] == portBSync3_ff[gi])
                  portBLvl_ff[gi] <= portBSync3_ff[gi];
            end
         end
      end
   endgenerate

   assign ctlAFull = {flagAStb, flagACtl, controlA_ff};
   assign ctlBFull = {flagBStb, flagBCtl, controlB_ff};

   // Read mux; port A always from pins, port B outputs from register
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rdData_ff <= RESET_BYTE;
      else if (busSel && busRd)
      begin
         case (regSel)
            SEL_PORT_A:
               rdData_ff <= controlA_ff[CTL_ACCESS] ? portALvl_ff : directionA_ff;
            SEL_CTL_A: rdData_ff <= ctlAFull;
            SEL_PORT_B:
               rdData_ff <= controlB_ff[CTL_ACCESS] ?
                  ((outputB_ff & directionB_ff) | (portBLvl_ff & ~directionB_ff)) :
                  directionB_ff;
            SEL_CTL_B: rdData_ff <= ctlBFull;
            default: rdData_ff <= RESET_BYTE;
         endcase
      end
   end
   assign rdData = rdData_ff;

   // Port drivers; a clear direction bit floats the line
   assign portAOut = outputA_ff;
   assign portAOe = directionA_ff;
   assign portBOut = outputB_ff;
   assign portBOe = directionB_ff;

   // Edge detectors for the four control pins
   pphi_edge_sync u_aStb (.clk(clk), .rstn(rstn), .pinIn(aStrobeIn),
      .riseSel(controlA_ff[CTL_STB_EDGE]), .level(aStbLvl), .activeEdge(aStbEdge));
   pphi_edge_sync u_aCtl (.clk(clk), .rstn(rstn), .pinIn(aCtlIn),
      .riseSel(controlA_ff[CTL_LINE_B4]), .level(aCtlLvl), .activeEdge(aCtlEdge));
   pphi_edge_sync u_bStb (.clk(clk), .rstn(rstn), .pinIn(bStrobeIn),
      .riseSel(controlB_ff[CTL_STB_EDGE]), .level(bStbLvl), .activeEdge(bStbEdge));
   pphi_edge_sync u_bCtl (.clk(clk), .rstn(rstn), .pinIn(bCtlIn),
      .riseSel(controlB_ff[CTL_LINE_B4]), .level(bCtlLvl), .activeEdge(bCtlEdge));

   // Side A: pulse on any access, handshake on port read
   pphi_ctl_side u_sideA (.clk(clk), .rstn(rstn), .ctlReg(ctlAFull),
      .strobeEdge(aStbEdge), .ctlEdge(aCtlEdge), .flagClr(rdPortA),
      .pulseTrig(anyAccess), .hsTrig(rdPortA),
      .flagStb(flagAStb), .flagCtl(flagACtl), .irqOe(irqAOe),
      .lineOut(aCtlOut), .lineOe(aCtlOe));
   // Side B: pulse and handshake on output register write
   pphi_ctl_side u_sideB (.clk(clk), .rstn(rstn), .ctlReg(ctlBFull),
      .strobeEdge(bStbEdge), .ctlEdge(bCtlEdge), .flagClr(rdPortB),
      .pulseTrig(wrPortB), .hsTrig(wrPortB),
      .flagStb(flagBStb), .flagCtl(flagBCtl), .irqOe(irqBOe),
      .lineOut(bCtlOut), .lineOe(bCtlOe));

   // Open drain: pull low only, never drive high
   assign irqANOut = 1'b0;
   assign irqANOe = irqAOe;
   assign irqBNOut = 1'b0;
   assign irqBNOe = irqBOe;

   // Assertions
   property p_flagA;
      @(posedge clk) disable iff (!rstn)
      aStbEdge |=> flagAStb;
   endproperty
   a_flagA: assert property (p_flagA) else $error("strobe A flag not set");

   property p_flagB;
      @(posedge clk) disable iff (!rstn)
      bStbEdge |=> flagBStb;
   endproperty
   a_flagB: assert property (p_flagB) else $error("strobe B flag not set");

   property p_ctlFlagA;
      @(posedge clk) disable iff (!rstn)
      (aCtlEdge && !controlA_ff[CTL_LINE_OUT]) |=> flagACtl;
   endproperty
   a_ctlFlagA: assert property (p_ctlFlagA) else $error("ctl A flag not set");

   property p_clrA;
      @(posedge clk) disable iff (!rstn)
      (rdPortA && !aStbEdge && !aCtlEdge) |=> !flagAStb && !flagACtl;
   endproperty
   a_clrA: assert property (p_clrA) else $error("A flags not cleared");

   property p_clrB;
      @(posedge clk) disable iff (!rstn)
      (rdPortB && !bStbEdge && !bCtlEdge) |=> !flagBStb && !flagBCtl;
   endproperty
   a_clrB: assert property (p_clrB) else $error("B flags not cleared");

   property p_irqA;
      @(posedge clk) disable iff (!rstn)
      irqANOe == ((flagAStb && controlA_ff[CTL_STB_IRQEN]) ||
         (flagACtl && controlA_ff[CTL_LINE_B3] && !controlA_ff[CTL_LINE_OUT]));
   endproperty
   a_irqA: assert property (p_irqA) else $error("irq A gating wrong");

   sequence s_pulseModeA;
      controlA_ff[5:3] == 3'b101;
   endsequence
   property p_pulseA;
      @(posedge clk) disable iff (!rstn)
      (s_pulseModeA and anyAccess) ##1 s_pulseModeA |-> !aCtlOut ##1 (aCtlOut || $past(anyAccess));
   endproperty
   a_pulseA: assert property (p_pulseA) else $error("pulse A shape wrong");

   property p_hsA;
      @(posedge clk) disable iff (!rstn)
      (controlA_ff[5:3] == 3'b100 && rdPortA) ##1 (controlA_ff[5:3] == 3'b100) |-> !aCtlOut;
   endproperty
   a_hsA: assert property (p_hsA) else $error("handshake A not low");

   property p_staticB;
      @(posedge clk) disable iff (!rstn)
      (controlB_ff[5:4] == 2'b11) [*2] |=> bCtlOut == $past(controlB_ff[CTL_LINE_B3]);
   endproperty
   a_staticB: assert property (p_staticB) else $error("static B level wrong");

   property p_ctlFlagB;
      @(posedge clk) disable iff (!rstn)
      (bCtlEdge && !controlB_ff[CTL_LINE_OUT]) |=> flagBCtl;
   endproperty
   a_ctlFlagB: assert property (p_ctlFlagB) else $error("ctl B flag not set");
   property p_pulseB;
      @(posedge clk) disable iff (!rstn)
      (controlB_ff[5:3] == 3'b101 && wrPortB) |=> !bCtlOut;
   endproperty
   a_pulseB: assert property (p_pulseB) else $error("pulse B not low");
   property p_hsRelA;
      @(posedge clk) disable iff (!rstn)
      (controlA_ff[5:3] == 3'b100 && aStbEdge && !rdPortA) |=> aCtlOut;
   endproperty
   a_hsRelA: assert property (p_hsRelA) else $error("handshake A not released");
   property p_hsB;
      @(posedge clk) disable iff (!rstn)
      (controlB_ff[5:3] == 3'b100 && wrPortB) |=> !bCtlOut;
   endproperty
   a_hsB: assert property (p_hsB) else $error("handshake B not low");
   property p_dir;
      @(posedge clk) disable iff (!rstn)
      portBOe == directionB_ff && portAOe == directionA_ff;
   endproperty
   a_dir: assert property (p_dir) else $error("direction enable wrong");
endmodule : pphi_parallel_port
`default_nettype wire

/* File: testbench/pphi_periph_model.sv */
// Purpose: Peripheral side of both ports, control lines and request wiring
// Assumes: Peripheral drives every data line that the design leaves as input
// Notes: A clamp pulls a pin low whatever drives it, like an overloaded output
`default_nettype none
module pphi_periph_model
(
   input wire logic [pphi_pkg::PORT_W-1:0] portAOut, // Design drive, port A
   input wire logic [pphi_pkg::PORT_W-1:0] portAOe, // Design enables, port A
   input wire logic [pphi_pkg::PORT_W-1:0] portBOut, // Design drive, port B
   input wire logic [pphi_pkg::PORT_W-1:0] portBOe, // Design enables, port B
   input wire logic [pphi_pkg::PORT_W-1:0] periphA, // Peripheral drive, port A
   input wire logic [pphi_pkg::PORT_W-1:0] clampA, // Lines held low, port A
   input wire logic [pphi_pkg::PORT_W-1:0] periphB, // Peripheral drive, port B
   input wire logic [pphi_pkg::PORT_W-1:0] clampB, // Lines held low, port B
   input wire logic aCtlOut, // Design control line A level
   input wire logic aCtlOe, // Design control line A enable
   input wire logic bCtlOut, // Design control line B level
   input wire logic bCtlOe, // Design control line B enable
   input wire logic aCtlDrv, // Peripheral level on line A
   input wire logic bCtlDrv, // Peripheral level on line B
   input wire logic irqANOut, // Request A pull-down level
   input wire logic irqANOe, // Request A pull-down enable
   input wire logic irqBNOut, // Request B pull-down level
   input wire logic irqBNOe, // Request B pull-down enable
   output logic [pphi_pkg::PORT_W-1:0] portAIn, // Resolved pins, port A
   output logic [pphi_pkg::PORT_W-1:0] portBIn, // Resolved pins, port B
   output logic aCtlIn, // Resolved control line A
   output logic bCtlIn, // Resolved control line B
   output logic irqAN, // Pulled-up request A
   output logic irqBN, // Pulled-up request B
   output logic irqWired // Both requests tied together
);
   import pphi_pkg::*;
   // Resolved pins; the clamp wins so read-back differences show up
   assign portAIn = ((portAOe & portAOut) | (~portAOe & periphA)) & ~clampA;
   assign portBIn = ((portBOe & portBOut) | (~portBOe & periphB)) & ~clampB;
   // Peripheral drives a control line only while the design releases it
   assign aCtlIn = aCtlOe ? aCtlOut : aCtlDrv;
   assign bCtlIn = bCtlOe ? bCtlOut : bCtlDrv;
   // Pull-up resistors; an idle line floats high, never to the last value
   assign irqAN = irqANOe ? irqANOut : 1'h1;
   assign irqBN = irqBNOe ? irqBNOut : 1'h1;
   assign irqWired = irqAN & irqBN;
endmodule : pphi_periph_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// Purpose: Self-checking bench for the dual parallel port with control lines
// Assumes: Bus strobes and pins change at the falling clock edge
// Notes: Pin edges reach the flags within a few cycles, so eight are allowed
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import pphi_pkg::*;
   logic clk, rstn, busSel, busRd, busWr, aStrobeIn, bStrobeIn, aCtlDrv, bCtlDrv;
   logic [1:0] regSel;
   logic [7:0] wrData, rdData, portAIn, portAOut, portAOe, portBIn, portBOut, portBOe;
   logic [7:0] periphA, clampA, periphB, clampB, got;
   logic aCtlIn, aCtlOut, aCtlOe, bCtlIn, bCtlOut, bCtlOe;
   logic irqANOut, irqANOe, irqBNOut, irqBNOe, irqAN, irqBN, irqWired;
   int mismatches = 0;
   int checksDone = 0;

   pphi_parallel_port u_pphi_parallel_port (.clk(clk), .rstn(rstn), .busSel(busSel),
      .busRd(busRd), .busWr(busWr), .regSel(regSel), .wrData(wrData), .rdData(rdData),
      .portAIn(portAIn), .portAOut(portAOut), .portAOe(portAOe), .portBIn(portBIn),
      .portBOut(portBOut), .portBOe(portBOe), .aStrobeIn(aStrobeIn), .aCtlIn(aCtlIn),
      .aCtlOut(aCtlOut), .aCtlOe(aCtlOe), .bStrobeIn(bStrobeIn), .bCtlIn(bCtlIn),
      .bCtlOut(bCtlOut), .bCtlOe(bCtlOe), .irqANOut(irqANOut), .irqANOe(irqANOe),
      .irqBNOut(irqBNOut), .irqBNOe(irqBNOe));

   pphi_periph_model u_pphi_periph_model (.portAOut(portAOut), .portAOe(portAOe),
      .portBOut(portBOut), .portBOe(portBOe), .periphA(periphA), .clampA(clampA),
      .periphB(periphB), .clampB(clampB), .aCtlOut(aCtlOut), .aCtlOe(aCtlOe),
      .bCtlOut(bCtlOut), .bCtlOe(bCtlOe), .aCtlDrv(aCtlDrv), .bCtlDrv(bCtlDrv),
      .irqANOut(irqANOut), .irqANOe(irqANOe), .irqBNOut(irqBNOut), .irqBNOe(irqBNOe),
      .portAIn(portAIn), .portBIn(portBIn), .aCtlIn(aCtlIn), .bCtlIn(bCtlIn),
      .irqAN(irqAN), .irqBN(irqBN), .irqWired(irqWired));

   // 40 MHz clock
   initial
   begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end

   // Verdict in one place for normal end and for hangs
   task automatic complete_run();
      if (mismatches == 0 && checksDone > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : complete_run

   task automatic check8(input logic [7:0] act, input logic [7:0] exp);
      checksDone++;
      if (act !== exp)
      begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, act, exp);
         mismatches++;
      end
   endtask : check8

   // One-cycle access; strobe held across exactly one rising edge
   task automatic busWrite(input logic [1:0] sel, input logic [7:0] data);
      @(negedge clk);
      busSel = 1'h1;
      busWr = 1'h1;
      regSel = sel;
      wrData = data;
      @(negedge clk);
      busSel = 1'h0;
      busWr = 1'h0;
   endtask : busWrite

   // Read data is registered, so it is settled at the next falling edge
   task automatic busRead(input logic [1:0] sel, output logic [7:0] data);
      @(negedge clk);
      busSel = 1'h1;
      busRd = 1'h1;
      regSel = sel;
      @(negedge clk);
      busSel = 1'h0;
      busRd = 1'h0;
      data = rdData;
   endtask : busRead

   task automatic settle();
      repeat (8) @(negedge clk);
   endtask : settle

   task automatic setPin(input int side, input int isCtl, input logic v);
      case ({side[0], isCtl[0]})
         2'h0: aStrobeIn = v;
         2'h1: aCtlDrv = v;
         2'h2: bStrobeIn = v;
         default: bCtlDrv = v;
      endcase
   endtask : setPin

   function automatic logic lineOf(input int side);
      return side ? bCtlOut : aCtlOut;
   endfunction : lineOf

   // Access that fires the control line: port A read, port B output write
   task automatic trigger(input int side);
      logic [7:0] d;
      if (side)
         busWrite(SEL_PORT_B, 8'h33);
      else
         busRead(SEL_PORT_A, d);
   endtask : trigger

   // Bounded wait for a control line level; running out ends the run
   task automatic waitLine(input int side, input logic exp);
      int i;
      i = 0;
      while (lineOf(side) !== exp && i < 40)
      begin
         @(negedge clk);
         i++;
      end
      check8({7'h00, lineOf(side)}, {7'h00, exp});
      if (i >= 40)
      begin
         mismatches++;
         complete_run();
      end
   endtask : waitLine

   // Pin set to the inactive level first, then the active edge; request gated by enable
   task automatic edgeCase(input int side, input int isCtl, input logic rise, input logic en);
      logic [7:0] cfg, d;
      logic [1:0] cs, ps;
      cs = side ? SEL_CTL_B : SEL_CTL_A;
      ps = side ? SEL_PORT_B : SEL_PORT_A;
      if (isCtl)
         cfg = 8'h04 | (rise ? 8'h10 : 8'h00) | (en ? 8'h08 : 8'h00);
      else
         cfg = 8'h04 | (rise ? 8'h02 : 8'h00) | (en ? 8'h01 : 8'h00);
      busWrite(cs, cfg);
      setPin(side, isCtl, ~rise);
      settle();
      busRead(ps, d);
      busRead(cs, d);
      check8(d, cfg);
      setPin(side, isCtl, rise);
      settle();
      busRead(cs, d);
      check8(d, cfg | (isCtl ? 8'h40 : 8'h80));
      d = {6'h00, side ? irqBN : irqAN, irqWired};
      check8(d, {6'h00, ~en, ~en});
      busRead(ps, d);
      busRead(cs, d);
      check8(d, cfg);
      check8({7'h00, irqWired}, 8'h01);
   endtask : edgeCase

   // Main sequence
   initial
   begin
      rstn = 1'h0;
      {busSel, busRd, busWr, aStrobeIn, bStrobeIn, aCtlDrv, bCtlDrv} = 7'h00;
      regSel = 2'h0;
      wrData = 8'h00;
      periphA = 8'h03;
      periphB = 8'hC3;
      clampA = 8'h80;
      clampB = 8'h02;
      repeat (12) @(negedge clk);
      rstn = 1'h1;
      // Reset state: every line an input, registers clear
      check8({portAOe | portBOe}, 8'h00);
      check8({6'h00, aCtlOe, bCtlOe}, 8'h00);
      busRead(SEL_CTL_A, got);
      check8(got, 8'h00);
      busRead(SEL_PORT_B, got);
      check8(got, 8'h00);
      // Direction and output registers behind the shared location
      busWrite(SEL_PORT_A, 8'hF0);
      busWrite(SEL_CTL_A, 8'h04);
      busWrite(SEL_PORT_A, 8'hA5);
      busWrite(SEL_PORT_B, 8'h0F);
      busWrite(SEL_CTL_B, 8'h04);
      busWrite(SEL_PORT_B, 8'h5A);
      settle();
      check8(portAOe, 8'hF0);
      check8(portAOut, 8'hA5);
      check8(portBOe, 8'h0F);
      check8(portBOut, 8'h5A);
      busRead(SEL_PORT_A, got);
      check8(got, 8'h23);
      busRead(SEL_PORT_B, got);
      check8(got, 8'hCA);
      busWrite(SEL_CTL_A, 8'h00);
      busRead(SEL_PORT_A, got);
      check8(got, 8'hF0);
      // Every edge choice and enable on all four lines
      for (int side = 0; side < 2; side++)
         for (int isCtl = 0; isCtl < 2; isCtl++)
            for (int m = 0; m < 4; m++)
               edgeCase(side, isCtl, m[1], m[0]);
      // Output modes of the control lines on both sides
      for (int side = 0; side < 2; side++)
      begin
         busWrite(side ? SEL_CTL_B : SEL_CTL_A, 8'h3C);
         repeat (2) @(negedge clk);
         check8({6'h00, lineOf(side), side ? bCtlOe : aCtlOe}, 8'h03);
         busWrite(side ? SEL_CTL_B : SEL_CTL_A, 8'h34);
         repeat (2) @(negedge clk);
         check8({7'h00, lineOf(side)}, 8'h00);
         busWrite(side ? SEL_CTL_B : SEL_CTL_A, 8'h2C);
         repeat (3) @(negedge clk);
         busRead(side ? SEL_PORT_B : SEL_CTL_B, got);
         check8({7'h00, lineOf(side)}, {7'h00, side == 1});
         repeat (2) @(negedge clk);
         trigger(side);
         check8({7'h00, lineOf(side)}, 8'h00);
         @(negedge clk);
         check8({7'h00, lineOf(side)}, 8'h01);
         busWrite(side ? SEL_CTL_B : SEL_CTL_A, 8'h24);
         setPin(side, 0, 1'h0);
         waitLine(side, 1'h1);
         setPin(side, 0, 1'h1);
         settle();
         trigger(side);
         check8({7'h00, lineOf(side)}, 8'h00);
         settle();
         check8({7'h00, lineOf(side)}, 8'h00);
         setPin(side, 0, 1'h0);
         waitLine(side, 1'h1);
      end
      complete_run();
   end

   // Hang guard
   initial
   begin
      repeat (100000) @(posedge clk);
      mismatches++;
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
